// *** tsi_switch_control_map.sv ***
// Control map, memories and output gating of the time-slot interchange switch
//
// Operation
// - A variable-delay channel n reaches output m after 32-(n-m) slots if m<n, m-n+32 if m is n..n+2, else m-n.
// - A constant-delay channel n reaches output m after 32+(32-n)+m slots on any stream pair.
// - Address bit 7 low reaches registers; high with bits 6 and 5 low, the low five bits pick channel 0 to 31.
// - Register addresses 0 to 4 are control, interface mode, frame alignment, offset 0 and offset 1.
// - A channel with enable 0 floats; with enable 1 it floats only when drive pin and stand-by are both 0.
// - Memory select 0 sends reads and writes to connection memory; 1 reads data memory, writes connection memory.
// - The processor can never write data memory.
// - The stream select field, bits 2 to 0, picks the stream subsection of channel accesses.
// - With block allow and begin both 1, every connection entry loads the value in 15:11 and zero in 10:0.
// - The delay-type bit of each connection entry picks variable (0) or constant (1) delay.
`include "tsi_switch_consts.svh"

module tsi_switch_control_map (
   // Clock and reset
   input  wire  logic                     clk,
   input  wire  logic                     srst,
   // Processor port
   input  wire  logic                     busSelect,
   input  wire  logic                     busRead,
   input  wire  logic                     busWrite,
   input  wire  logic [7:0]               busAddr,
   input  wire  tsi_switch_pkg::word_t    busWdata,
   output       tsi_switch_pkg::word_t    busRdata,
   output       logic                     busAck,
   // Output drive pin
   input  wire  logic                     outputDrivePin,
   // Serial data, one byte per stream per slot
   input  wire  logic [63:0]              rxData,
   output       logic [63:0]              txData,
   output       logic [7:0]               txEnable,
   output       logic                     slotStart,
   output       tsi_switch_pkg::chan_t    slotIndex
);
   import tsi_switch_pkg::*;

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   word_t        switchControl_reg;
   word_t        ifaceMode_reg;
   word_t        frameOffset0_reg;
   word_t        frameOffset1_reg;
   word_t        connMem [`NUM_STREAMS][`NUM_CHANNELS];
   byte_t        dataMem [`NUM_STREAMS][`NUM_BUFFERS][`NUM_CHANNELS];
   block_state_t blockState_reg;
   logic [7:0]   blockIdx_reg;
   logic [8:0]   slotTimer_reg;
   chan_t        slotCnt_reg;
   buf_t         writeBuf_reg;
   logic [2:0]   drivePinSync_reg;
   logic         drivePin_reg;

   // -------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------
   logic    isChan;
   logic    isReg;
   stream_t curStream;
   chan_t   curChan;
   logic    busWr;
   logic    busRd;
   logic    blockGo;
   assign isChan    = busAddr[`ADDR_MEM_BIT] && !busAddr[`ADDR_HI_LO]
                      && !busAddr[`ADDR_HI_HI];
   assign isReg     = !busAddr[`ADDR_MEM_BIT];
   assign curStream = switchControl_reg[`CTL_STREAM_HI:`CTL_STREAM_LO];
   assign curChan   = busAddr[4:0];
   assign busWr     = busSelect && busWrite;
   assign busRd     = busSelect && busRead && !busWrite;
   assign blockGo   = switchControl_reg[`CTL_BLOCK_ALLOW] && ifaceMode_reg[`IMS_BEGIN];

   // -------------------------------------------------------------
   // Slot timing
   // -------------------------------------------------------------
   logic slotTick;
   buf_t nextBuf;
   assign slotTick = (slotTimer_reg == 9'(`SLOT_CYCLES - 1));
   assign nextBuf  = (slotCnt_reg == 5'd31) ? ((writeBuf_reg == 2'd2) ? 2'd0 : writeBuf_reg + 2'd1)
                                            : writeBuf_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         slotTimer_reg <= 9'h000;
         slotCnt_reg   <= 5'h00;
         writeBuf_reg  <= 2'h0;
      end else begin
         slotTimer_reg <= slotTick ? 9'h000 : slotTimer_reg + 9'h001;
         if (slotTick) begin
            slotCnt_reg  <= slotCnt_reg + 5'h01;
            writeBuf_reg <= nextBuf;
         end
      end
   end

   // -------------------------------------------------------------
   // Drive pin synchroniser
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         drivePinSync_reg <= 3'h0;
         drivePin_reg     <= 1'b0;
      end else begin
         drivePinSync_reg <= {drivePinSync_reg[1:0], outputDrivePin};
         if (drivePinSync_reg[1] == drivePinSync_reg[2]) begin
            drivePin_reg <= drivePinSync_reg[2];
         end
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         switchControl_reg <= `CTL_RESET;
         ifaceMode_reg     <= `IMS_RESET;
         frameOffset0_reg  <= `OFFSET_RESET;
         frameOffset1_reg  <= `OFFSET_RESET;
      end else begin
         if (busWr && isReg) begin
            unique case (busAddr[6:0])
               `OFS_SWITCH_CONTROL: begin
                  switchControl_reg <= busWdata & `CTL_WRITE_MASK;
               end
               `OFS_IFACE_MODE: begin
                  ifaceMode_reg <= busWdata & `IMS_WRITE_MASK;
               end
               `OFS_FRAME_OFFSET0: begin
                  frameOffset0_reg <= busWdata;
               end
               `OFS_FRAME_OFFSET1: begin
                  frameOffset1_reg <= busWdata;
               end
               default: begin
               end
            endcase
         end
         // Begin bit drops by itself once the whole memory is loaded
         if (blockState_reg == BP_LOAD && blockIdx_reg == 8'hff) begin
            ifaceMode_reg[`IMS_BEGIN] <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Block programming sequencer
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         blockState_reg <= BP_IDLE;
         blockIdx_reg   <= 8'h00;
      end else begin
         unique case (blockState_reg)
            BP_IDLE: begin
               blockIdx_reg <= 8'h00;
               if (blockGo) begin
                  blockState_reg <= BP_LOAD;
               end
            end
            BP_LOAD: begin
               blockIdx_reg <= blockIdx_reg + 8'h01;
               // Clearing either bit aborts the load
               if (!blockGo || blockIdx_reg == 8'hff) begin
                  blockState_reg <= BP_IDLE;
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Connection memory
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (blockState_reg == BP_LOAD && blockGo) begin
         connMem[blockIdx_reg[7:5]][blockIdx_reg[4:0]] <=
            {ifaceMode_reg[`IMS_VALUE_HI:`IMS_VALUE_LO], 11'h000};
      end else if (busWr && isChan) begin
         connMem[curStream][curChan] <= busWdata;
      end
   end

   // -------------------------------------------------------------
   // Processor reads
   // -------------------------------------------------------------
   buf_t  readBuf;
   word_t regRead;
   assign readBuf = (writeBuf_reg == 2'd0) ? 2'd2 : writeBuf_reg - 2'd1;

   always_comb begin
      regRead = 16'h0000;
      unique case (busAddr[6:0])
         `OFS_SWITCH_CONTROL: regRead = switchControl_reg;
         `OFS_IFACE_MODE:     regRead = ifaceMode_reg;
         `OFS_FRAME_ALIGN:    regRead = `FRAME_ALIGN_RESET;
         `OFS_FRAME_OFFSET0:  regRead = frameOffset0_reg;
         `OFS_FRAME_OFFSET1:  regRead = frameOffset1_reg;
         default:             regRead = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         busRdata <= 16'h0000;
         busAck   <= 1'b0;
      end else begin
         busAck <= busWr || busRd;
         if (busRd) begin
            if (isReg) begin
               busRdata <= regRead;
            end else if (isChan && switchControl_reg[`CTL_MEM_SELECT]) begin
               busRdata <= {8'h00, dataMem[curStream][readBuf][curChan]};
            end else if (isChan) begin
               busRdata <= connMem[curStream][curChan];
            end else begin
               busRdata <= 16'h0000;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Switching path, one lane per stream
   // -------------------------------------------------------------
   chan_t outChan;
   assign outChan = slotCnt_reg + 5'h01;

   always_ff @(posedge clk) begin
      if (srst) begin
         slotStart <= 1'b0;
         slotIndex <= 5'h00;
      end else begin
         slotStart <= slotTick;
         if (slotTick) begin
            slotIndex <= outChan;
         end
      end
   end

   genvar s;
   generate
      for (s = 0; s < `NUM_STREAMS; s++) begin : g_lane
         word_t entry;
         chan_t srcChan;
         buf_t  srcBuf;
         logic  sameFrame;
         stream_t srcStream;
         byte_t   srcByte;
         assign entry     = connMem[s][outChan];
         assign srcStream = entry[`CM_SRC_STREAM_HI:`CM_SRC_STREAM_LO];
         // Channel 31 into channel 0 is stored on this very edge: take it from the pins
         assign srcByte   = (srcBuf == writeBuf_reg && srcChan == slotCnt_reg)
                            ? rxData[srcStream*8 +: 8] : dataMem[srcStream][srcBuf][srcChan];
         assign srcChan   = entry[`CM_SRC_CHAN_HI:`CM_SRC_CHAN_LO];
         assign sameFrame = {1'b0, outChan} > ({1'b0, srcChan} + 6'd2);
         always_comb begin
            if (entry[`CM_CONST_DELAY]) begin
               srcBuf = (nextBuf == 2'd2) ? 2'd0 : nextBuf + 2'd1;
            end else if (sameFrame) begin
               srcBuf = nextBuf;
            end else begin
               srcBuf = (nextBuf == 2'd0) ? 2'd2 : nextBuf - 2'd1;
            end
         end

         always_ff @(posedge clk) begin
            if (slotTick) begin
               dataMem[s][writeBuf_reg][slotCnt_reg] <= rxData[s*8 +: 8];
            end
         end

         always_ff @(posedge clk) begin
            if (srst) begin
               txData[s*8 +: 8] <= 8'h00;
               txEnable[s]      <= 1'b0;
            end else if (slotTick) begin
               txData[s*8 +: 8] <= entry[`CM_PROC_MODE] ? entry[7:0] : srcByte;
               txEnable[s] <= entry[`CM_OUT_ENABLE]
                  && (drivePin_reg || ifaceMode_reg[`IMS_STANDBY]);
            end
         end
      end
   endgenerate

endmodule : tsi_switch_control_map

// *** tsi_switch_consts.svh ***
// Offsets, field positions, reset values and timing counts of the switch control map
`ifndef TSI_SWITCH_CONSTS_SVH
`define TSI_SWITCH_CONSTS_SVH

// -------------------------------------------------------------
// Address decode
// -------------------------------------------------------------
`define ADDR_MEM_BIT        7
`define ADDR_HI_LO          6
`define ADDR_HI_HI          5
`define OFS_SWITCH_CONTROL  7'h00
`define OFS_IFACE_MODE      7'h01
`define OFS_FRAME_ALIGN     7'h02
`define OFS_FRAME_OFFSET0   7'h03
`define OFS_FRAME_OFFSET1   7'h04

// -------------------------------------------------------------
// Switch control fields
// -------------------------------------------------------------
`define CTL_BLOCK_ALLOW     5
`define CTL_MEM_SELECT      4
`define CTL_STREAM_HI       2
`define CTL_STREAM_LO       0
`define CTL_WRITE_MASK      16'h0037
`define CTL_RESET           16'h0000

// -------------------------------------------------------------
// Interface mode fields, offset and frame alignment reset values
// -------------------------------------------------------------
`define IMS_VALUE_HI        9
`define IMS_VALUE_LO        5
`define IMS_BEGIN           4
`define IMS_STANDBY         3
`define IMS_WRITE_MASK      16'h03fc
`define IMS_RESET           16'h0000
`define OFFSET_RESET        16'h0000
`define FRAME_ALIGN_RESET   16'h0000

// -------------------------------------------------------------
// Connection memory fields
// -------------------------------------------------------------
`define CM_CONST_DELAY      14
`define CM_PROC_MODE        13
`define CM_OUT_ENABLE       12
`define CM_SRC_STREAM_HI    10
`define CM_SRC_STREAM_LO    8
`define CM_SRC_CHAN_HI      4
`define CM_SRC_CHAN_LO      0
`define CM_PROG_HI          15
`define CM_PROG_LO          11

// -------------------------------------------------------------
// Frame geometry and timing
// -------------------------------------------------------------
`define NUM_STREAMS         8
`define NUM_CHANNELS        32
`define NUM_BUFFERS         3
`define CLK_PERIOD_PS       10000
`define SLOT_TIME_PS        3906250
`define SLOT_CYCLES         (`SLOT_TIME_PS / `CLK_PERIOD_PS)

`endif

// *** tsi_switch_pkg.sv ***
// Types shared by the switch control map
package tsi_switch_pkg;
   typedef logic [15:0] word_t;
   typedef logic [7:0]  byte_t;
   typedef logic [2:0]  stream_t;
   typedef logic [4:0]  chan_t;
   typedef logic [1:0]  buf_t;
   typedef enum logic [0:0] {
      BP_IDLE = 1'b0,
      BP_LOAD = 1'b1
   } block_state_t;
endpackage : tsi_switch_pkg

// *** tsi_switch_control_map_chk.sv ***
// Port-level assertions of the switch control map
`include "tsi_switch_consts.svh"

module tsi_switch_control_map_chk (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  srst,
   // Processor port
   input wire logic                  busSelect,
   input wire logic                  busRead,
   input wire logic                  busWrite,
   input wire logic [7:0]            busAddr,
   input wire tsi_switch_pkg::word_t busRdata,
   input wire logic                  busAck,
   // Serial side
   input wire logic [63:0]           txData,
   input wire logic [7:0]            txEnable,
   input wire logic                  slotStart,
   input wire tsi_switch_pkg::chan_t slotIndex
);
   import tsi_switch_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic       rdReq;
   logic       unmapped;
   logic [9:0] gapCnt;
   logic       seen;
   chan_t      lastIdx;
   assign rdReq    = busSelect && busRead && !busWrite;
   assign unmapped = busAddr[7] ? (busAddr[6:5] != 2'b00) : (busAddr[6:0] > 7'h04);
   // -------------------------------------------------------------
   // Slot spacing tracker
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         gapCnt  <= '0;
         seen    <= 1'b0;
         lastIdx <= '0;
      end else if (slotStart) begin
         gapCnt  <= '0;
         seen    <= 1'b1;
         lastIdx <= slotIndex;
      end else begin
         gapCnt <= gapCnt + 10'h001;
      end
   end
   chk_write_ack: assert property (busSelect && busWrite |=> busAck)
      else $error("write not acknowledged");
   chk_read_ack: assert property (rdReq |=> busAck)
      else $error("read not acknowledged");
   chk_ack_cause: assert property (!(busSelect && (busWrite || busRead)) |=> !busAck)
      else $error("acknowledge without access");
   chk_unmapped_zero: assert property (rdReq && unmapped |=> busRdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_align_zero: assert property (rdReq && busAddr == 8'h02 |=> busRdata == 16'h0000)
      else $error("alignment read not zero");
   chk_ctrl_unused: assert property (rdReq && busAddr == 8'h00 |=> (busRdata & 16'hffc8) == 0)
      else $error("control unused bits set");
   chk_slot_gap: assert property (seen && slotStart |-> gapCnt == `SLOT_CYCLES - 1)
      else $error("slot length wrong");
   chk_slot_next: assert property (seen && slotStart |-> slotIndex == chan_t'(lastIdx + 1))
      else $error("slot index skipped");
   chk_start_pulse: assert property (slotStart |=> !slotStart)
      else $error("slot start too long");
   chk_tx_at_slot: assert property ($changed(txData) || $changed(txEnable) |-> slotStart)
      else $error("transmit changed mid slot");
   cover property (rdReq ##1 busAck);
   cover property (busSelect && busWrite && busAddr[7]);
   cover property (slotStart && slotIndex == 5'h1f);
endmodule : tsi_switch_control_map_chk

bind tsi_switch_control_map tsi_switch_control_map_chk chk (
   .clk(clk), .srst(srst), .busSelect(busSelect), .busRead(busRead), .busWrite(busWrite),
   .busAddr(busAddr), .busRdata(busRdata), .busAck(busAck), .txData(txData),
   .txEnable(txEnable), .slotStart(slotStart), .slotIndex(slotIndex)
);

// *** tsi_host_model.sv ***
// Host processor model driving the switch control port
`include "tsi_switch_consts.svh"

module tsi_host_model (
   // Clock
   input wire logic                  clk,
   // Requests toward the switch
   output     logic                  busSelect,
   output     logic                  busRead,
   output     logic                  busWrite,
   output     logic [7:0]            busAddr,
   output     tsi_switch_pkg::word_t busWdata,
   // Answer
   input wire tsi_switch_pkg::word_t busRdata,
   input wire logic                  busAck
);
   timeunit 1ns;
   timeprecision 1ps;
   import tsi_switch_pkg::*;
   int ackMiss;
   initial begin
      ackMiss   = 0;
      busSelect = 1'b0;
      busRead   = 1'b0;
      busWrite  = 1'b0;
      busAddr   = 8'h00;
      busWdata  = 16'h0000;
   end
   // Channel addresses are composed by callers as 100 + five channel bits
   task automatic access(input logic isWrite, input logic [7:0] addr, input word_t wdata,
                         output word_t rdata);
      int n;
      n = 0;
      @(negedge clk);
      busSelect <= 1'b1;
      busWrite  <= isWrite;
      busRead   <= !isWrite;
      busAddr   <= addr;
      busWdata  <= (addr == 8'h00) ? (wdata & `CTL_WRITE_MASK) : wdata;
      do begin
         @(posedge clk);
         n++;
      end while (busAck !== 1'b1 && n < 8);
      // A request left unanswered counts against the run
      if (busAck !== 1'b1) begin
         ackMiss++;
      end
      rdata = busRdata;
      @(negedge clk);
      busSelect <= 1'b0;
      busWrite  <= 1'b0;
      busRead   <= 1'b0;
      busAddr   <= ~addr;
      busWdata  <= ~busWdata;
      // Let the acknowledge of the held request pass
      @(posedge clk);
   endtask : access
endmodule : tsi_host_model

// *** tb.sv ***
// Self-checking testbench of the switch control map
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tsi_switch_pkg::*;
   logic        clk, srst, outputDrivePin, busSelect, busRead, busWrite, busAck, slotStart;
   logic [7:0]  busAddr, txEnable;
   logic [63:0] rxData, txData;
   word_t       busWdata, busRdata, rd;
   chan_t       slotIndex;
   int          miscompares, checkCount, cycles, gs;

   tsi_switch_control_map dut (.clk(clk), .srst(srst), .busSelect(busSelect),
      .busRead(busRead), .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata),
      .busRdata(busRdata), .busAck(busAck), .outputDrivePin(outputDrivePin), .rxData(rxData),
      .txData(txData), .txEnable(txEnable), .slotStart(slotStart), .slotIndex(slotIndex));
   tsi_host_model host (.clk(clk), .busSelect(busSelect), .busRead(busRead),
      .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata),
      .busAck(busAck));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Each input slot carries the low byte of the running slot count
   always @(negedge clk) begin
      if (slotStart === 1'b1) begin
         gs = gs + 1;
         rxData <= {8{gs[7:0]}};
      end
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         miscompares = miscompares + 1;
         giveVerdict();
      end
   end
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic check(input word_t seen, input word_t exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input word_t d);
      host.access(1'b1, a, d, rd);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input word_t e);
      host.access(1'b0, a, 16'h0000, rd);
      check(rd, e);
   endtask : rdchk
   task automatic waitSlot(input int m);
      do @(negedge clk);
      while (slotStart !== 1'b1 || (m >= 0 && slotIndex !== m[4:0]));
      #1;
   endtask : waitSlot
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic testRegs;
      rdchk(8'h00, 16'h0000);
      rdchk(8'h01, 16'h0000);
      wr(8'h00, 16'h0035);
      wr(8'h01, 16'h0008);
      wr(8'h03, 16'ha5c3);
      wr(8'h04, 16'h3c5a);
      wr(8'h02, 16'hffff);
      rdchk(8'h00, 16'h0035);
      rdchk(8'h01, 16'h0008);
      rdchk(8'h02, 16'h0000);
      rdchk(8'h03, 16'ha5c3);
      rdchk(8'h04, 16'h3c5a);
      rdchk(8'h05, 16'h0000);
      rdchk(8'hc0, 16'h0000);
      $display("done: registers");
   endtask : testRegs
   task automatic testBlock;
      wr(8'h00, 16'h0020);
      wr(8'h01, 16'h00d0);
      repeat (300) @(negedge clk);
      rdchk(8'h01, 16'h00c0);
      wr(8'h00, 16'h0003);
      rdchk(8'h9f, 16'h3000);
      $display("done: block programming");
   endtask : testBlock
   task automatic testStreams;
      for (int s = 0; s < 8; s++) begin
         wr(8'h00, 16'(s));
         wr(8'h87, 16'h3000 | 16'(s));
      end
      for (int s = 0; s < 8; s++) begin
         wr(8'h00, 16'(s));
         rdchk(8'h87, 16'h3000 | 16'(s));
      end
      wr(8'h00, 16'h0014);
      wr(8'h83, 16'h1234);
      host.access(1'b0, 8'h83, 16'h0000, rd);
      check(rd & 16'hff00, 16'h0000);
      wr(8'h00, 16'h0004);
      rdchk(8'h83, 16'h1234);
      $display("done: streams and memory select");
   endtask : testStreams
   task automatic testGate;
      for (int i = 0; i < 4; i++) begin
         wr(8'h01, i[0] ? 16'h00c8 : 16'h00c0);
         @(negedge clk);
         outputDrivePin = i[1];
         waitSlot(-1);
         waitSlot(-1);
         check({8'h00, txEnable}, (i == 0) ? 16'h0000 : 16'h00ff);
      end
      wr(8'h00, 16'h0006);
      wr(8'h89, 16'h2000);
      wr(8'h00, 16'h0002);
      wr(8'h85, 16'h30a7);
      waitSlot(5);
      check({8'h00, txData[23:16]}, 16'h00a7);
      waitSlot(9);
      check({8'h00, txEnable}, 16'h00bf);
      $display("done: output gating");
   endtask : testGate
   task automatic testDelay;
      wr(8'h00, 16'h0004);
      wr(8'h85, 16'h110a);
      wr(8'h00, 16'h0005);
      wr(8'h8b, 16'h110a);
      wr(8'h00, 16'h0006);
      wr(8'h94, 16'h110a);
      wr(8'h00, 16'h0007);
      wr(8'h85, 16'h510a);
      wr(8'h00, 16'h0003);
      wr(8'h80, 16'h111f);
      repeat (3) waitSlot(0);
      check({8'h00, txData[31:24]}, {8'h00, 8'(gs - 1)});
      waitSlot(5);
      check({8'h00, txData[39:32]}, {8'h00, 8'(gs - 27)});
      check({8'h00, txData[63:56]}, {8'h00, 8'(gs - 59)});
      waitSlot(11);
      check({8'h00, txData[47:40]}, {8'h00, 8'(gs - 33)});
      waitSlot(20);
      check({8'h00, txData[55:48]}, {8'h00, 8'(gs - 10)});
      wr(8'h00, 16'h0014);
      wr(8'h83, 16'h1234);
      host.access(1'b0, 8'h83, 16'h0000, rd);
      check(rd, {8'h00, 8'(gs - 49)});
      $display("done: throughput delay");
   endtask : testDelay
   task automatic giveVerdict;
      $display("checks %0d, mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : giveVerdict

   initial begin
      srst = 1'b1;
      outputDrivePin = 1'b0;
      rxData = 64'h0;
      miscompares = 0;
      checkCount = 0;
      cycles = 0;
      gs = 0;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      testRegs();
      testBlock();
      testStreams();
      testGate();
      testDelay();
      check(16'(host.ackMiss), 16'h0000);
      giveVerdict();
   end
endmodule : tb
